/* File: sie_pkg.sv */
// Constants, modes and carrier types for the serial channel interrupt enable block.
package sie_pkg;

	// ****************************************************************
	// Register byte offsets on the APB.
	// ****************************************************************
	localparam logic [11:0] SIE_SUM_EN_OFS = 12'h000;
	localparam logic [11:0] SIE_CHG_EN_OFS = 12'h004;
	localparam logic [11:0] SIE_ERR_EN_OFS = 12'h008;
	localparam logic [11:0] SIE_FRM_EN_OFS = 12'h00c;
	localparam logic [11:0] SIE_MODE_OFS = 12'h010;
	localparam logic [11:0] SIE_STAT_OFS = 12'h014;

	// ****************************************************************
	// Serial modes of the channel.
	// ****************************************************************
	typedef enum logic [1:0] {
		SIE_ASYNC = 2'h0,
		SIE_BYTE = 2'h1,
		SIE_BIT = 2'h2
	} sie_mode_t;

	// ****************************************************************
	// Field positions of the summary enable, summary status and frame enable.
	// ****************************************************************
	localparam int SIE_TXS_POS = 7;
	localparam int SIE_RXS_POS = 6;
	localparam int SIE_TXR_POS = 1;
	localparam int SIE_RXR_POS = 0;
	localparam int SIE_END_MSG_POS = 7;

	// ****************************************************************
	// Implemented bits per register and per mode, and the change bits that fold into each summary.
	// ****************************************************************
	localparam logic [7:0] SIE_SUM_USED = 8'hc3;
	localparam logic [7:0] SIE_CHG_USED = 8'hdf;
	localparam logic [7:0] SIE_ERR_USED = 8'hfc;
	localparam logic [7:0] SIE_FRM_USED = 8'h80;
	localparam logic [7:0] SIE_CHG_ASYNC = 8'h4f;
	localparam logic [7:0] SIE_CHG_BYTE = 8'hdc;
	localparam logic [7:0] SIE_CHG_BIT = 8'hdf;
	localparam logic [7:0] SIE_ERR_ASYNC = 8'h78;
	localparam logic [7:0] SIE_ERR_BYTE = 8'h0c;
	localparam logic [7:0] SIE_ERR_BIT = 8'hfc;
	localparam logic [7:0] SIE_CHG_TX_SET = 8'hc8;
	localparam logic [7:0] SIE_CHG_RX_SET = 8'h17;

	// ****************************************************************
	// Values after reset.
	// ****************************************************************
	localparam logic [7:0] SIE_EN_RST = 8'h00;
	localparam sie_mode_t SIE_MODE_RST = SIE_ASYNC;

	// Status flags delivered by the serial channel.
	typedef struct packed {
		logic tx_ready_flag;
		logic rx_ready_flag;
		logic [7:0] change_status_reg;
		logic [7:0] error_status_reg;
		logic end_msg_frame;
	} sie_status_t;

endpackage

/* File: sie_top.sv */
// Interrupt enable masks of one serial channel with an APB register port.
//
// Overview of operation
// - Host request only while a status bit and its enable are both one.
// - Summary bit 7 gates the transmit summary flag in every mode.
// - Summary bit 6 gates the receive summary flag in every mode.
// - Summary bit 1 gates the transmit ready flag in every mode.
// - Summary bit 0 gates the receive ready flag in every mode.
// - Summary bits 5 to 2 read zero; host writes zero.
// - Same AND gating for all three pairs and the frame pair.
// - Change bit 7 folds underrun into transmit summary; reserved when async.
// - Change bit 6 folds transmitter quiet into transmit summary, all modes.
// - Change bit 4 folds pattern detect into receive summary; reserved async.
// - Change bit 3 folds CTS change into transmit summary, all modes.
// - Change bit 2 folds DCD change into receive summary, all modes.
// - Change bit 1 folds break or abort detect; reserved in byte sync.
// - Change bit 0 folds break end or quiet; reserved in byte sync.
// - Change bit 5 reads zero; host writes zero.
// - Error bit 7 folds end of message, bit sync only.
// - Error bit 6 folds multiprocessor or short frame; reserved byte sync.
// - Error bit 5 folds parity or abort; reserved in byte sync.
// - Error bit 4 folds framing or residual bit; reserved byte sync.
// - Error bit 3 folds receive overrun in all modes.
// - Error bit 2 folds CRC fault in sync modes; reserved async.
// - Error bits 1 and 0 read zero; host writes zero.
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module sie_top (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Channel status flags.
	input wire sie_pkg::sie_status_t stat,
	// Summary flags and host request.
	output logic tx_summary_flag,
	output logic rx_summary_flag,
	output logic host_irq
);

	// ****************************************************************
	// Mode decoding.
	// ****************************************************************

	// Change enable bits that exist in the given mode.
	function automatic logic [7:0] chg_mask(input sie_pkg::sie_mode_t m);
		case (m)
			sie_pkg::SIE_BYTE: return sie_pkg::SIE_CHG_BYTE;
			sie_pkg::SIE_BIT: return sie_pkg::SIE_CHG_BIT;
			default: return sie_pkg::SIE_CHG_ASYNC;
		endcase
	endfunction

	// Error enable bits that exist in the given mode.
	function automatic logic [7:0] err_mask(input sie_pkg::sie_mode_t m);
		case (m)
			sie_pkg::SIE_BYTE: return sie_pkg::SIE_ERR_BYTE;
			sie_pkg::SIE_BIT: return sie_pkg::SIE_ERR_BIT;
			default: return sie_pkg::SIE_ERR_ASYNC;
		endcase
	endfunction

	// Frame enable exists only in bit synchronous mode.
	function automatic logic [7:0] frm_mask(input sie_pkg::sie_mode_t m);
		case (m)
			sie_pkg::SIE_BIT: return sie_pkg::SIE_FRM_USED;
			default: return 8'h00;
		endcase
	endfunction

	// Whether an address hits a mapped register.
	function automatic logic addr_ok(input logic [11:0] a);
		case (a)
			sie_pkg::SIE_SUM_EN_OFS,
			sie_pkg::SIE_CHG_EN_OFS,
			sie_pkg::SIE_ERR_EN_OFS,
			sie_pkg::SIE_FRM_EN_OFS,
			sie_pkg::SIE_MODE_OFS,
			sie_pkg::SIE_STAT_OFS: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// ****************************************************************
	// Register storage.
	// ****************************************************************
	logic [7:0] sum_en_q;
	logic [7:0] chg_en_q;
	logic [7:0] err_en_q;
	logic [7:0] frm_en_q;
	sie_pkg::sie_mode_t mode_q;
	logic [31:0] prdata_q;
	logic tx_sum_q;
	logic rx_sum_q;
	logic irq_q;
	logic [7:0] eff_chg;
	logic [7:0] eff_err;
	logic [7:0] eff_frm;
	logic [7:0] sum_view;
	logic tx_sum_d;
	logic rx_sum_d;
	logic irq_d;
	logic access;
	logic setup_rd;
	logic wr_ok;

	// ****************************************************************
	// APB handshake.
	// ****************************************************************

	// Zero wait states: read data is fetched in the setup cycle.
	assign access = psel & penable;
	assign setup_rd = psel & ~penable & ~pwrite;
	assign pready = access;
	assign pslverr = access & ~addr_ok(paddr);
	assign prdata = prdata_q;

	// A write lands only with lane 0 strobed; upper lanes hold nothing.
	assign wr_ok = access & pwrite & addr_ok(paddr) & pstrb[0];

	// Summary enable; unused bits are never stored.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sum_en_q <= sie_pkg::SIE_EN_RST;
		end else if (wr_ok && paddr == sie_pkg::SIE_SUM_EN_OFS) begin
			sum_en_q <= pwdata[7:0] & sie_pkg::SIE_SUM_USED;
		end
	end

	// Change enable; mode masking is applied on use so a mode switch
	// brings back what software last wrote.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chg_en_q <= sie_pkg::SIE_EN_RST;
		end else if (wr_ok && paddr == sie_pkg::SIE_CHG_EN_OFS) begin
			chg_en_q <= pwdata[7:0] & sie_pkg::SIE_CHG_USED;
		end
	end

	// Error enable.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_en_q <= sie_pkg::SIE_EN_RST;
		end else if (wr_ok && paddr == sie_pkg::SIE_ERR_EN_OFS) begin
			err_en_q <= pwdata[7:0] & sie_pkg::SIE_ERR_USED;
		end
	end

	// Frame enable, end of message only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frm_en_q <= sie_pkg::SIE_EN_RST;
		end else if (wr_ok && paddr == sie_pkg::SIE_FRM_EN_OFS) begin
			frm_en_q <= pwdata[7:0] & sie_pkg::SIE_FRM_USED;
		end
	end

	// Mode; the undefined code is ignored so the mode stays legal.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= sie_pkg::SIE_MODE_RST;
		end else if (wr_ok && paddr == sie_pkg::SIE_MODE_OFS && pwdata[1:0] != 2'h3) begin
			mode_q <= sie_pkg::sie_mode_t'(pwdata[1:0]);
		end
	end

	// ****************************************************************
	// Gating and folding.
	// ****************************************************************

	// Enables as the current mode sees them.
	assign eff_chg = chg_en_q & chg_mask(mode_q);
	assign eff_err = err_en_q & err_mask(mode_q);
	assign eff_frm = frm_en_q & frm_mask(mode_q);

	// Underrun, quiet and CTS change fold into the transmit summary.
	assign tx_sum_d = |(stat.change_status_reg & eff_chg & sie_pkg::SIE_CHG_TX_SET);

	// Pattern, DCD, break, all errors and frame end fold into receive.
	assign rx_sum_d = (|(stat.change_status_reg & eff_chg & sie_pkg::SIE_CHG_RX_SET))
		| (|(stat.error_status_reg & eff_err))
		| (stat.end_msg_frame & eff_frm[sie_pkg::SIE_END_MSG_POS]);

	// Summary status as the host sees it.
	assign sum_view = {tx_sum_q, rx_sum_q, 4'h0, stat.tx_ready_flag, stat.rx_ready_flag};

	// Host request: any summary bit with its enable.
	assign irq_d = |(sum_view & sum_en_q);

	// Summary flags are registered so the outputs are glitch free.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_sum_q <= 1'b0;
			rx_sum_q <= 1'b0;
		end else begin
			tx_sum_q <= tx_sum_d;
			rx_sum_q <= rx_sum_d;
		end
	end

	// The request is a level and falls on the clock after no pair is live.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	assign tx_summary_flag = tx_sum_q;
	assign rx_summary_flag = rx_sum_q;
	assign host_irq = irq_q;

	// ****************************************************************
	// Read data.
	// ****************************************************************

	// Reserved and mode reserved bits read zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup_rd) begin
			case (paddr)
				sie_pkg::SIE_SUM_EN_OFS: prdata_q <= {24'h00_0000, sum_en_q};
				sie_pkg::SIE_CHG_EN_OFS: prdata_q <= {24'h00_0000, eff_chg};
				sie_pkg::SIE_ERR_EN_OFS: prdata_q <= {24'h00_0000, eff_err};
				sie_pkg::SIE_FRM_EN_OFS: prdata_q <= {24'h00_0000, eff_frm};
				sie_pkg::SIE_MODE_OFS: prdata_q <= {30'h0000_0000, mode_q};
				sie_pkg::SIE_STAT_OFS: prdata_q <= {23'h00_0000, irq_q, sum_view};
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************************************************
	// Checks.
	// ****************************************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Nothing live on the summary side.
	sequence s_no_source;
		!(tx_summary_flag && sum_en_q[sie_pkg::SIE_TXS_POS])
			&& !(rx_summary_flag && sum_en_q[sie_pkg::SIE_RXS_POS])
			&& !(stat.tx_ready_flag && sum_en_q[sie_pkg::SIE_TXR_POS])
			&& !(stat.rx_ready_flag && sum_en_q[sie_pkg::SIE_RXR_POS]);
	endsequence

	// A read setup of the summary enable register.
	sequence s_rd_sum;
		psel && !penable && !pwrite && paddr == sie_pkg::SIE_SUM_EN_OFS;
	endsequence

	// Only the change flags given by the mask are set.
	function automatic logic only_chg(input logic [7:0] m);
		return (stat.change_status_reg & ~m) == 8'h00 && (stat.change_status_reg & m) != 8'h00;
	endfunction

	// Only the error flags given by the mask are set and nothing else feeds
	// the receive summary; the helper keeps the silence checks short.
	function automatic logic only_err(input logic [7:0] m);
		return (stat.error_status_reg & ~m) == 8'h00
			&& (stat.error_status_reg & m) != 8'h00
			&& (stat.change_status_reg & sie_pkg::SIE_CHG_RX_SET) == 8'h00 && !stat.end_msg_frame;
	endfunction

	// A read setup of the register at the given offset.
	sequence s_rd_at(logic [11:0] ofs);
		psel && !penable && !pwrite && paddr == ofs;
	endsequence

	a_no_cause_quiet: assert property (s_no_source |=> !host_irq)
		else $error("request raised with no live pair");
	a_tx_sum_irq: assert property (tx_summary_flag && sum_en_q[7] |=> host_irq)
		else $error("transmit summary did not raise the request");
	a_rx_sum_irq: assert property (rx_summary_flag && sum_en_q[6] |=> host_irq)
		else $error("receive summary did not raise the request");
	a_tx_rdy_irq: assert property (stat.tx_ready_flag && sum_en_q[1] |=> host_irq)
		else $error("transmit ready did not raise the request");
	a_rx_rdy_irq: assert property (stat.rx_ready_flag && sum_en_q[0] |=> host_irq)
		else $error("receive ready did not raise the request");
	a_sum_unused: assert property (s_rd_sum |=> prdata[5:2] == 4'h0 && prdata[31:8] == 24'h0)
		else $error("unused summary enable bits read nonzero");
	a_underrun_tx: assert property (stat.change_status_reg[7] && chg_en_q[7]
		&& mode_q != sie_pkg::SIE_ASYNC |=> tx_summary_flag)
		else $error("underrun did not set transmit summary");
	a_quiet_tx: assert property (stat.change_status_reg[6] && chg_en_q[6] |=> tx_summary_flag)
		else $error("quiet flag did not set transmit summary");
	a_cts_tx: assert property (stat.change_status_reg[3] && chg_en_q[3] |=> tx_summary_flag)
		else $error("CTS change did not set transmit summary");
	a_dcd_rx: assert property (stat.change_status_reg[2] && chg_en_q[2] |=> rx_summary_flag)
		else $error("DCD change did not set receive summary");
	a_byte_break_off: assert property (mode_q == sie_pkg::SIE_BYTE && only_chg(8'h03)
		&& stat.error_status_reg == 8'h00 && !stat.end_msg_frame |=> !rx_summary_flag)
		else $error("break enables acted in byte sync");
	a_overrun_rx: assert property (stat.error_status_reg[3] && err_en_q[3] |=> rx_summary_flag)
		else $error("overrun did not set receive summary");
	a_crc_async_off: assert property (mode_q == sie_pkg::SIE_ASYNC
		&& stat.error_status_reg == 8'h04 && (stat.change_status_reg & eff_chg) == 8'h00
		&& !stat.end_msg_frame |=> !rx_summary_flag)
		else $error("CRC enable acted in async mode");
	a_irq_follows: assert property ($fell(irq_d) |=> $fell(host_irq))
		else $error("request did not fall after the pairs cleared");

	// ****************************************************************
	// Checks on mode dependent sources and reserved read bits.
	// ****************************************************************

	// Sources that exist only in some modes must reach their summary there.
	a_pattern_rx: assert property (stat.change_status_reg[4] && chg_en_q[4]
		&& mode_q != sie_pkg::SIE_ASYNC |=> rx_summary_flag)
		else $error("pattern detect did not set receive summary");
	a_break_det_rx: assert property (stat.change_status_reg[1] && chg_en_q[1]
		&& mode_q != sie_pkg::SIE_BYTE |=> rx_summary_flag)
		else $error("break or abort detect did not set receive summary");
	a_break_end_rx: assert property (stat.change_status_reg[0] && chg_en_q[0]
		&& mode_q != sie_pkg::SIE_BYTE |=> rx_summary_flag)
		else $error("break end or quiet detect did not set receive summary");
	a_end_msg_rx: assert property (stat.error_status_reg[7] && err_en_q[7]
		&& mode_q == sie_pkg::SIE_BIT |=> rx_summary_flag)
		else $error("end of message did not set receive summary");
	a_multiproc_rx: assert property (stat.error_status_reg[6] && err_en_q[6]
		&& mode_q != sie_pkg::SIE_BYTE |=> rx_summary_flag)
		else $error("multiprocessor or short frame did not set receive summary");
	a_parity_rx: assert property (stat.error_status_reg[5] && err_en_q[5]
		&& mode_q != sie_pkg::SIE_BYTE |=> rx_summary_flag)
		else $error("parity or abort did not set receive summary");
	a_framing_rx: assert property (stat.error_status_reg[4] && err_en_q[4]
		&& mode_q != sie_pkg::SIE_BYTE |=> rx_summary_flag)
		else $error("framing or residual bit did not set receive summary");
	a_crc_rx: assert property (stat.error_status_reg[2] && err_en_q[2]
		&& mode_q != sie_pkg::SIE_ASYNC |=> rx_summary_flag)
		else $error("CRC fault did not set receive summary");
	a_frame_rx: assert property (stat.end_msg_frame && frm_en_q[sie_pkg::SIE_END_MSG_POS]
		&& mode_q == sie_pkg::SIE_BIT |=> rx_summary_flag)
		else $error("frame end did not set receive summary");

	// Mode dependent sources stay silent in the modes where their enables are reserved; the transmit summary stays clear with no live pair.
	a_underrun_off: assert property (mode_q == sie_pkg::SIE_ASYNC
		&& (stat.change_status_reg & sie_pkg::SIE_CHG_TX_SET) == 8'h80 |=> !tx_summary_flag)
		else $error("underrun enable acted in async mode");
	a_pattern_off: assert property (mode_q == sie_pkg::SIE_ASYNC
		&& (stat.change_status_reg & sie_pkg::SIE_CHG_RX_SET) == 8'h10
		&& stat.error_status_reg == 8'h00 && !stat.end_msg_frame |=> !rx_summary_flag)
		else $error("pattern detect enable acted in async mode");
	a_end_msg_off: assert property (mode_q != sie_pkg::SIE_BIT && only_err(8'h80)
		|=> !rx_summary_flag)
		else $error("end of message enable acted outside bit sync");
	a_byte_err_off: assert property (mode_q == sie_pkg::SIE_BYTE && only_err(8'h70)
		|=> !rx_summary_flag)
		else $error("error enables acted in byte sync");
	a_frame_off: assert property (mode_q != sie_pkg::SIE_BIT && stat.end_msg_frame
		&& stat.error_status_reg == 8'h00
		&& (stat.change_status_reg & sie_pkg::SIE_CHG_RX_SET) == 8'h00 |=> !rx_summary_flag)
		else $error("frame enable acted outside bit sync");
	a_tx_sum_clear: assert property ((stat.change_status_reg & chg_en_q
		& sie_pkg::SIE_CHG_TX_SET) == 8'h00 |=> !tx_summary_flag)
		else $error("transmit summary set with no live pair");

	// Reserved bits read zero whatever was written, and so do the async reserved change and byte sync reserved error bits.
	a_chg_rd_unused: assert property (s_rd_at(sie_pkg::SIE_CHG_EN_OFS)
		|=> prdata[31:8] == 24'h00_0000 && !prdata[5])
		else $error("unused change enable bits read nonzero");
	a_err_rd_unused: assert property (s_rd_at(sie_pkg::SIE_ERR_EN_OFS)
		|=> prdata[31:8] == 24'h00_0000 && prdata[1:0] == 2'h0)
		else $error("unused error enable bits read nonzero");
	a_chg_rd_async: assert property (s_rd_at(sie_pkg::SIE_CHG_EN_OFS)
		##0 mode_q == sie_pkg::SIE_ASYNC |=> !prdata[7] && !prdata[4])
		else $error("async reserved change enables read nonzero");
	a_err_rd_byte: assert property (s_rd_at(sie_pkg::SIE_ERR_EN_OFS)
		##0 mode_q == sie_pkg::SIE_BYTE |=> prdata[7:4] == 4'h0)
		else $error("byte sync reserved error enables read nonzero");

endmodule

`default_nettype wire

/* File: sie_host.sv */
// Host processor model that runs APB transfers on behalf of the bench.
`timescale 1ns/1ns
`default_nettype none

module sie_host (
	// Clock.
	input wire logic pclk,
	// APB master side.
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Raised when a transfer never completes.
	output logic hung
);
	// Idle bus from time zero so the slave never sees an unknown select.
	initial begin
		{psel, penable, pwrite, hung} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		pstrb = 4'h0;
	end

	// One transfer; keep masks the write data, and only a scenario that means
	// to poke reserved bits hands in a wider mask than the legal one.
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] keep, input logic [3:0] st, output logic [31:0] rd,
		output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d & keep;
		pstrb <= st;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (!(psel && penable && pready === 1'b1) && n < 50);
		if (n >= 50) hung <= 1'b1;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

`default_nettype wire

/* File: serial_irq_enable_mask_bench.sv */
// Self-checking bench for the serial channel interrupt enable block.
`timescale 1ns/1ns
`default_nettype none

module serial_irq_enable_mask_bench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, hung, txs, rxs, irq, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	sie_pkg::sie_status_t stat = '0;
	int n_fail = 0;
	int checks = 0;
	int en[4] = '{0, 0, 0, 0};
	int used[4] = '{8'hc3, 8'hdf, 8'hfc, 8'h80};
	int md = 0;

	// Free running 250 MHz clock.
	always #2 pclk = ~pclk;

	sie_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .stat(stat), .tx_summary_flag(txs),
		.rx_summary_flag(rxs), .host_irq(irq));

	sie_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hung(hung));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// A stuck handshake ends the run through the same report.
	always @(posedge hung) begin
		n_fail++;
		summarize();
	end

	// ****************************************************************
	// Reference model of the enable registers.
	// ****************************************************************
	// Read mask of each register in the current mode; reserved bits read zero.
	function automatic int rmask(int i);
		case (i)
			0: return 8'hc3;
			1: return md == 0 ? 8'h4f : md == 1 ? 8'hdc : 8'hdf;
			2: return md == 0 ? 8'h78 : md == 1 ? 8'h0c : 8'hfc;
			default: return md == 2 ? 8'h80 : 8'h00;
		endcase
	endfunction

	// Stored bits survive a mode change, so only the mode mask hides them.
	task automatic wr(int i, logic [31:0] d, logic [31:0] keep, logic [3:0] st);
		host.xfer(1'b1, 12'(4 * i), d, keep, st, rd, err);
		chk("write error", 32'(err), 32'(i > 5));
		if (st[0] && i < 4) en[i] = d & keep & used[i];
		if (st[0] && i == 4 && d[1:0] != 2'h3) md = d[1:0];
	endtask

	task automatic rdchk(int i, logic [31:0] exp);
		host.xfer(1'b0, 12'(4 * i), 32'h00000000, 32'h00000000, 4'h0, rd, err);
		chk("read data", rd, exp);
		chk("read error", 32'(err), 32'(i > 5));
	endtask

	// Let the new status reach the summaries and the request first; only then
	// does the model see the status that the design is working on.
	task automatic flags();
		logic [7:0] c, e;
		logic ets, ers, ei;
		repeat (3) @(posedge pclk);
		#1;
		c = 8'(stat.change_status_reg & en[1] & rmask(1));
		e = 8'(stat.error_status_reg & en[2] & rmask(2));
		ets = |(c & 8'hc8);
		ers = |(c & 8'h17) | |e | (stat.end_msg_frame && (en[3] & rmask(3)) != 0);
		ei = en[0][7] & ets | en[0][6] & ers;
		ei = ei | en[0][1] & stat.tx_ready_flag | en[0][0] & stat.rx_ready_flag;
		chk("tx summary", 32'(txs), 32'(ets));
		chk("rx summary", 32'(rxs), 32'(ers));
		chk("host request", 32'(irq), 32'(ei));
		rdchk(5, {23'h0, ei, ets, ers, 4'h0, stat.tx_ready_flag, stat.rx_ready_flag});
	endtask

	// ****************************************************************
	// Main sequence.
	// ****************************************************************
	initial begin
		int i, k;
		k = $urandom(25);
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 6; i++) rdchk(i, 32'h00000000);
		// Unmapped address and a write with the low lane strobe off change nothing.
		wr(6, 32'h000000ff, 32'h000000ff, 4'hf);
		rdchk(6, 32'h00000000);
		wr(0, 32'h000000c3, 32'h000000c3, 4'he);
		rdchk(0, 32'h00000000);
		// Random enables with reserved bits set, sparse status, every mode.
		for (k = 0; k < 240; k++) begin
			if (k % 40 == 0) wr(4, 32'(k / 40 % 4), 32'h00000003, 4'hf);
			i = $urandom % 4;
			wr(i, $urandom, 32'h000000ff, 4'($urandom));
			@(posedge pclk);
			stat <= 19'($urandom & $urandom & $urandom);
			flags();
			rdchk(i, en[i] & rmask(i));
		end
		summarize();
	end
endmodule

`default_nettype wire
